// *** src/mblr_reader.sv ***
// Archive log record reader: serves log groups to serial RTU clients.
// Assumes a byte receiver with frame-gap strobe and a byte transmitter,
// both on sys_clk, and a log store answering record lookups.
module mblr_reader
   import mblr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] slave_addr,
   input wire logic meter_four_path,
   input wire logic measurement_unit_select,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_frame_end,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output mblr_rec_req_t rec_req,
   output logic rec_req_valid,
   input wire logic rec_ack,
   input wire logic rec_found,
   input wire mblr_rec_hdr_t rec_hdr,
   output logic [5:0] rec_byte_addr,
   input wire logic [7:0] rec_byte
);

   typedef enum logic [6:0] {
      ST_RX = 7'b000_0001,
      ST_CHECK = 7'b000_0010,
      ST_FETCH = 7'b000_0100,
      ST_SEND = 7'b000_1000,
      ST_CRC_LOAD = 7'b001_0000,
      ST_CRC_LO = 7'b010_0000,
      ST_CRC_HI = 7'b100_0000
   } mblr_state_t;

   mblr_state_t state_reg, state_next;
   logic [7:0] frame_reg [0:7];
   logic [7:0] frame_next [0:7];
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] byte_reg, byte_next;
   logic [7:0] pos_reg, pos_next;
   logic [7:0] total_reg, total_next;
   logic [7:0] func_reg, func_next;
   logic [7:0] code_reg, code_next;
   mblr_rec_hdr_t hdr_reg, hdr_next;
   logic zero_reg, zero_next;
   logic [5:0] addr_reg, addr_next;
   mblr_rec_req_t req_reg, req_next;

   logic rx_crc_clear, rx_crc_load, tx_crc_clear, tx_crc_load;
   logic [15:0] rx_crc, tx_crc;
   logic [15:0] raw_num, reg_num, qty, slot, max_index;
   logic is_hourly, is_daily, grp_ok;
   logic [2:0] grp;
   logic [7:0] pos_inc, sel;

   function automatic logic [3:0] slot_group(input logic [4:0] s);
      case (s)
         5'h00: slot_group = {1'b1, GRP_COMMON};
         5'h01: slot_group = {1'b1, GRP_GAS};
         5'h02: slot_group = {1'b1, GRP_CHORD_A};
         5'h03: slot_group = {1'b1, GRP_CHORD_B};
         5'h04: slot_group = {1'b1, GRP_CHORD_C};
         5'h05: slot_group = {1'b1, GRP_CHORD_D};
         SLOT_ACCUM: slot_group = {1'b1, GRP_ACCUM};
         default: slot_group = 4'h0;
      endcase
   endfunction

   function automatic logic [7:0] group_bytes(input logic [2:0] g);
      case (g)
         GRP_COMMON: group_bytes = GRP_BYTES_COMMON;
         GRP_GAS: group_bytes = GRP_BYTES_GAS;
         GRP_ACCUM: group_bytes = GRP_BYTES_ACCUM;
         default: group_bytes = GRP_BYTES_CHORD;
      endcase
   endfunction

   function automatic logic [7:0] hdr_byte(input mblr_rec_hdr_t h,
                                           input logic [7:0] i);
      logic [95:0] s;
      s = h << {i[3:0], 3'b000};
      return s[95:88];
   endfunction

   mblr_crc16 u_rx_crc (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clear(rx_crc_clear),
      .load(rx_crc_load),
      .data(rx_data),
      .crc(rx_crc)
   );

   mblr_crc16 u_tx_crc (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clear(tx_crc_clear),
      .load(tx_crc_load),
      .data(byte_reg),
      .crc(tx_crc)
   );

   // Request decode
   always_comb begin
      raw_num = {frame_reg[2], frame_reg[3]};
      qty = {frame_reg[4], frame_reg[5]};
      reg_num = raw_num;
      if (raw_num >= ALIAS_FIRST) begin
         reg_num = raw_num - ALIAS_OFFSET;
      end
      is_hourly = (reg_num >= HOURLY_COMMON_GROUP) &&
                  (reg_num <= HOURLY_LAST);
      is_daily = (reg_num >= DAILY_COMMON_GROUP) &&
                 (reg_num <= DAILY_LAST);
      slot = is_daily ? reg_num - DAILY_COMMON_GROUP :
                        reg_num - HOURLY_COMMON_GROUP;
      {grp_ok, grp} = slot_group(slot[4:0]);
      if (!(is_hourly || is_daily)) begin
         grp_ok = 1'b0;
      end
      max_index = is_daily ? DAILY_MAX : HOURLY_MAX;
   end

   // Next transmit byte
   always_comb begin
      pos_inc = 8'(pos_reg + 8'h01);
      if (pos_inc == 8'h01) begin
         sel = func_reg;
      end else if (pos_inc == 8'h02) begin
         sel = code_reg;
      end else if (pos_inc < PAYLOAD_POS) begin
         sel = hdr_byte(hdr_reg, 8'(pos_inc - HDR_POS));
      end else begin
         sel = zero_reg ? 8'h00 : rec_byte;
      end
   end

   always_comb begin
      state_next = state_reg;
      frame_next = frame_reg;
      cnt_next = cnt_reg;
      byte_next = byte_reg;
      pos_next = pos_reg;
      total_next = total_reg;
      func_next = func_reg;
      code_next = code_reg;
      hdr_next = hdr_reg;
      zero_next = zero_reg;
      addr_next = addr_reg;
      req_next = req_reg;
      rx_crc_clear = 1'b0;
      rx_crc_load = 1'b0;
      tx_crc_clear = 1'b0;
      tx_crc_load = 1'b0;
      case (state_reg)
         ST_RX: begin
            if (rx_valid) begin
               if (cnt_reg < RX_BYTES) begin
                  frame_next[cnt_reg[2:0]] = rx_data;
                  rx_crc_load = 1'b1;
               end
               if (cnt_reg != RX_OVER) begin
                  cnt_next = 4'(cnt_reg + 4'h1);
               end
            end
            if (rx_frame_end && cnt_reg != 4'h0) begin
               state_next = ST_CHECK;
            end
         end
         ST_CHECK: begin
            rx_crc_clear = 1'b1;
            cnt_next = 4'h0;
            state_next = ST_RX;
            if (cnt_reg == RX_BYTES && rx_crc == CRC_RESIDUE &&
                frame_reg[0] == slave_addr) begin
               func_next = frame_reg[1] | EXC_FLAG;
               total_next = EXC_FRAME_BYTES;
               byte_next = slave_addr;
               pos_next = 8'h00;
               tx_crc_clear = 1'b1;
               zero_next = 1'b0;
               state_next = ST_SEND;
               if (frame_reg[1] != FUNC_READ_HOLD) begin
                  code_next = EXC_ILLEGAL_FUNCTION;
               end else if (!grp_ok) begin
                  code_next = EXC_ILLEGAL_ADDRESS;
               end else if (qty == 16'h0000 || qty > max_index) begin
                  code_next = EXC_ILLEGAL_VALUE;
               end else begin
                  req_next.daily = is_daily;
                  req_next.group = grp;
                  req_next.index = qty;
                  req_next.measurement_unit_select =
                     measurement_unit_select;
                  state_next = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (rec_ack) begin
               byte_next = slave_addr;
               pos_next = 8'h00;
               tx_crc_clear = 1'b1;
               addr_next = 6'h00;
               state_next = ST_SEND;
               if (rec_found) begin
                  func_next = FUNC_READ_HOLD;
                  code_next = group_bytes(req_reg.group);
                  total_next = 8'(EXC_FRAME_BYTES +
                                  group_bytes(req_reg.group));
                  hdr_next = rec_hdr;
                  zero_next = (req_reg.group == GRP_GAS) ||
                              (!meter_four_path &&
                               (req_reg.group == GRP_CHORD_C ||
                                req_reg.group == GRP_CHORD_D));
               end else begin
                  func_next = FUNC_READ_HOLD | EXC_FLAG;
                  code_next = EXC_ILLEGAL_VALUE;
                  total_next = EXC_FRAME_BYTES;
               end
            end
         end
         ST_SEND: begin
            if (tx_ready) begin
               tx_crc_load = 1'b1;
               if (pos_reg == 8'(total_reg - 8'h01)) begin
                  state_next = ST_CRC_LOAD;
               end else begin
                  pos_next = pos_inc;
                  byte_next = sel;
                  if (pos_inc >= PAYLOAD_POS) begin
                     addr_next = 6'(addr_reg + 6'h01);
                  end
               end
            end
         end
         ST_CRC_LOAD: begin
            byte_next = tx_crc[7:0];
            state_next = ST_CRC_LO;
         end
         ST_CRC_LO: begin
            if (tx_ready) begin
               byte_next = tx_crc[15:8];
               state_next = ST_CRC_HI;
            end
         end
         ST_CRC_HI: begin
            if (tx_ready) begin
               state_next = ST_RX;
            end
         end
         default: begin
            state_next = ST_RX;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_RX;
         for (int i = 0; i < 8; i++) begin
            frame_reg[i] <= 8'h00;
         end
         cnt_reg <= 4'h0;
         byte_reg <= 8'h00;
         pos_reg <= 8'h00;
         total_reg <= 8'h00;
         func_reg <= 8'h00;
         code_reg <= 8'h00;
         hdr_reg <= '0;
         zero_reg <= 1'b0;
         addr_reg <= 6'h00;
         req_reg <= '0;
      end else begin
         state_reg <= state_next;
         frame_reg <= frame_next;
         cnt_reg <= cnt_next;
         byte_reg <= byte_next;
         pos_reg <= pos_next;
         total_reg <= total_next;
         func_reg <= func_next;
         code_reg <= code_next;
         hdr_reg <= hdr_next;
         zero_reg <= zero_next;
         addr_reg <= addr_next;
         req_reg <= req_next;
      end
   end

   assign tx_data = byte_reg;
   assign tx_valid = (state_reg == ST_SEND) || (state_reg == ST_CRC_LO) ||
                     (state_reg == ST_CRC_HI);
   assign rec_req = req_reg;
   assign rec_req_valid = (state_reg == ST_FETCH);
   assign rec_byte_addr = addr_reg;

endmodule

// *** common/mblr_pkg.sv ***
// Constants and carriers for the archive log record reader.
// Assumes a byte-wide serial front end and a log store on sys_clk.
package mblr_pkg;

   // Protocol bytes
   localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

   // Request frame layout
   localparam logic [3:0] RX_BYTES = 4'h8;
   localparam logic [3:0] RX_OVER = 4'h9;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   // Response layout
   localparam logic [7:0] EXC_FRAME_BYTES = 8'h03;
   localparam logic [7:0] HDR_POS = 8'h03;
   localparam logic [7:0] PAYLOAD_POS = 8'h0f;
   localparam logic [7:0] HDR_BYTES = 8'h0c;

   // Log register numbers
   localparam logic [15:0] HOURLY_COMMON_GROUP = 16'h1c21;
   localparam logic [15:0] HOURLY_GAS_GROUP = 16'h1c22;
   localparam logic [15:0] HOURLY_CHORD_A_GROUP = 16'h1c23;
   localparam logic [15:0] HOURLY_CHORD_B_GROUP = 16'h1c24;
   localparam logic [15:0] HOURLY_CHORD_C_GROUP = 16'h1c25;
   localparam logic [15:0] HOURLY_CHORD_D_GROUP = 16'h1c26;
   localparam logic [15:0] HOURLY_ACCUMULATOR_GROUP = 16'h1c2b;
   localparam logic [15:0] HOURLY_LAST = 16'h1c38;
   localparam logic [15:0] DAILY_COMMON_GROUP = 16'h1c3a;
   localparam logic [15:0] DAILY_GAS_GROUP = 16'h1c3b;
   localparam logic [15:0] DAILY_CHORD_A_GROUP = 16'h1c3c;
   localparam logic [15:0] DAILY_CHORD_B_GROUP = 16'h1c3d;
   localparam logic [15:0] DAILY_CHORD_C_GROUP = 16'h1c3e;
   localparam logic [15:0] DAILY_CHORD_D_GROUP = 16'h1c3f;
   localparam logic [15:0] DAILY_ACCUMULATOR_GROUP = 16'h1c44;
   localparam logic [15:0] DAILY_LAST = 16'h1c51;
   localparam logic [15:0] ALIAS_OFFSET = 16'h9c41;
   localparam logic [15:0] ALIAS_FIRST = 16'hb862;

   // Table depths
   localparam logic [15:0] HOURLY_MAX = 16'h10e0;
   localparam logic [15:0] DAILY_MAX = 16'h0721;

   // Group codes, slot offsets within a table
   localparam logic [2:0] GRP_COMMON = 3'h0;
   localparam logic [2:0] GRP_GAS = 3'h1;
   localparam logic [2:0] GRP_CHORD_A = 3'h2;
   localparam logic [2:0] GRP_CHORD_B = 3'h3;
   localparam logic [2:0] GRP_CHORD_C = 3'h4;
   localparam logic [2:0] GRP_CHORD_D = 3'h5;
   localparam logic [2:0] GRP_ACCUM = 3'h6;
   localparam logic [4:0] SLOT_ACCUM = 5'h0a;

   // Data bytes per group
   localparam logic [7:0] GRP_BYTES_CHORD = 8'h3c;
   localparam logic [7:0] GRP_BYTES_COMMON = 8'h3c;
   localparam logic [7:0] GRP_BYTES_GAS = 8'h3c;
   localparam logic [7:0] GRP_BYTES_ACCUM = 8'h3c;

   typedef struct packed {
      logic [31:0] seq;
      logic [31:0] date;
      logic [31:0] time_of_day;
   } mblr_rec_hdr_t;

   typedef struct packed {
      logic daily;
      logic [2:0] group;
      logic [15:0] index;
      logic measurement_unit_select;
   } mblr_rec_req_t;

endpackage

// *** src/mblr_crc16.sv ***
// Byte-serial RTU frame check accumulator.
// Assumes bytes are offered on sys_clk, one per load pulse.
module mblr_crc16
   import mblr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic load,
   input wire logic [7:0] data,
   output logic [15:0] crc
);

   logic [15:0] crc_reg;
   logic [15:0] crc_next;

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         if (r[0]) begin
            r = (r >> 1) ^ CRC_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   always_comb begin
      crc_next = crc_reg;
      if (clear) begin
         crc_next = CRC_INIT;
      end else if (load) begin
         crc_next = crc_byte(crc_reg, data);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         crc_reg <= CRC_INIT;
      end else begin
         crc_reg <= crc_next;
      end
   end

   assign crc = crc_reg;

endmodule

// *** dv/mblr_store_model.sv ***
// Log store model answering record lookups of the reader.
// Assumes the reader's fetch handshake on sys_clk; index 7 is empty.
module mblr_store_model
   import mblr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire mblr_rec_req_t rec_req,
   input wire logic rec_req_valid,
   output logic rec_ack,
   output logic rec_found,
   output mblr_rec_hdr_t rec_hdr,
   input wire logic [5:0] rec_byte_addr,
   output logic [7:0] rec_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;
   logic [15:0] idx_reg;
   logic unit_reg;
   mblr_rec_hdr_t hdr;
   // Prompt or slow answer, chosen by index
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 4'h0;
         rec_ack <= 1'b0;
         idx_reg <= 16'h0000;
         unit_reg <= 1'b0;
      end else begin
         rec_ack <= 1'b0;
         if (rec_req_valid && !rec_ack) begin
            if (wait_reg == {rec_req.index[1:0], 2'b00}) begin
               rec_ack <= 1'b1;
               wait_reg <= 4'h0;
               idx_reg <= rec_req.index;
               unit_reg <= rec_req.measurement_unit_select;
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end
      end
   end
   // Header: sequence, YYYYMMDD date, HHMMSS time
   assign hdr = {16'h0000, idx_reg,
      32'd20220513, 32'd75545};
   // Header and found lines show inverted values outside the answer cycle
   assign rec_hdr = rec_ack ? hdr : ~hdr;
   assign rec_found = (idx_reg != 16'h0007) ^ !rec_ack;
   assign rec_byte = {unit_reg, 1'b0, rec_byte_addr} ^
      idx_reg[7:0];
endmodule

// *** dv/mblr_reader_monitor.sv ***
// Port checker for the archive log record reader.
// Assumes all reader ports on sys_clk with asynchronous arst_n.
module mblr_reader_monitor
   import mblr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] slave_addr,
   input wire logic meter_four_path,
   input wire logic rx_valid,
   input wire logic rx_frame_end,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire mblr_rec_req_t rec_req,
   input wire logic rec_req_valid,
   input wire logic rec_ack,
   input wire logic rec_found,
   input wire mblr_rec_hdr_t rec_hdr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic [6:0] pos_reg, pos_next;
   logic armed_reg, armed_next, found_reg, found_next;
   logic [2:0] grp_reg, grp_next;
   logic [95:0] hdr_reg, hdr_next;
   logic take, start, body, zero_grp;
   logic [7:0] hdr_byte;
   assign take = tx_valid && tx_ready;
   assign start = rec_req_valid && rec_ack;
   assign body = tx_valid && armed_reg && found_reg;
   assign hdr_byte = 8'(hdr_reg >> (8 * (14 - pos_reg)));
   assign zero_grp = (grp_reg == GRP_GAS) || (!meter_four_path &&
      (grp_reg == GRP_CHORD_C || grp_reg == GRP_CHORD_D));
   // Byte position within an answer after a lookup
   always_comb begin
      pos_next = pos_reg;
      armed_next = armed_reg;
      found_next = found_reg;
      grp_next = grp_reg;
      hdr_next = hdr_reg;
      if (start) begin
         pos_next = 7'h00;
         armed_next = 1'b1;
         found_next = rec_found;
         grp_next = rec_req.group;
         hdr_next = rec_hdr;
      end else begin
         if (take) pos_next = pos_reg + 7'h01;
         if (rx_valid) armed_next = 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_reg <= 7'h00;
         armed_reg <= 1'b0;
         found_reg <= 1'b0;
         grp_reg <= 3'h0;
         hdr_reg <= '0;
      end else begin
         pos_reg <= pos_next;
         armed_reg <= armed_next;
         found_reg <= found_next;
         grp_reg <= grp_next;
         hdr_reg <= hdr_next;
      end
   end
   chk_req_hold: assert property (rec_req_valid && !rec_ack |=>
      rec_req_valid && $stable(rec_req)) else $error("lookup changed");
   chk_req_drop: assert property (start |=> !rec_req_valid)
      else $error("lookup not dropped");
   chk_start_addr: assert property (
      start |=> tx_valid && tx_data == slave_addr) else $error("bad start");
   chk_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data)) else $error("byte not held");
   chk_func_code: assert property (
      body && pos_reg == 7'd1 |-> tx_data == FUNC_READ_HOLD)
      else $error("bad function byte");
   chk_byte_count: assert property (
      body && pos_reg == 7'd2 |-> tx_data == 8'h3c) else $error("bad count");
   chk_hdr_order: assert property (
      body && pos_reg >= 7'd3 && pos_reg < 7'd15 |-> tx_data == hdr_byte)
      else $error("bad header byte");
   chk_zero_data: assert property (
      body && zero_grp && pos_reg >= 7'd15 && pos_reg < 7'd63 |->
      tx_data == 8'h00) else $error("payload not zero");
   chk_exc_code: assert property (
      tx_valid && armed_reg && !found_reg && pos_reg inside {7'd1, 7'd2}
      |-> tx_data == (pos_reg == 7'd1 ? 8'h83 : 8'h03))
      else $error("bad exception");
   chk_crc_gap: assert property (
      take && armed_reg && pos_reg == (found_reg ? 7'd62 : 7'd2) |=>
      !tx_valid ##1 tx_valid) else $error("bad check gap");
   chk_check_gap: assert property (
      rx_frame_end |=> !tx_valid && !rec_req_valid) else $error("early act");
endmodule
bind mblr_reader mblr_reader_monitor mon_u (.sys_clk, .arst_n,
   .slave_addr, .meter_four_path, .rx_valid, .rx_frame_end, .tx_data,
   .tx_valid, .tx_ready, .rec_req, .rec_req_valid, .rec_ack, .rec_found,
   .rec_hdr);

// *** dv/mblr_reader_bench.sv ***
// Testbench for the archive log record reader.
// Assumes the store model and the bound port checker.
module mblr_reader_bench
   import mblr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, arst_n = 0, meter_four_path = 1, tx_ready = 1;
   logic measurement_unit_select = 0, rx_valid = 0, rx_frame_end = 0;
   logic [7:0] slave_addr = 8'h20, rx_data = 8'h00, tx_data, rec_byte;
   logic tx_valid, rec_req_valid, rec_ack, rec_found, stall = 0;
   mblr_rec_req_t rec_req, last_req;
   mblr_rec_hdr_t rec_hdr;
   logic [5:0] rec_byte_addr;
   logic [7:0] exp_q[$], got_q[$];
   int error_cnt = 0, tests_run = 0, cyc = 0;
   localparam logic [15:0] REGS[14] = '{HOURLY_COMMON_GROUP,
      HOURLY_GAS_GROUP, HOURLY_CHORD_A_GROUP, HOURLY_CHORD_B_GROUP,
      HOURLY_CHORD_C_GROUP, HOURLY_CHORD_D_GROUP, HOURLY_ACCUMULATOR_GROUP,
      DAILY_COMMON_GROUP, DAILY_GAS_GROUP, DAILY_CHORD_A_GROUP,
      DAILY_CHORD_B_GROUP, DAILY_CHORD_C_GROUP, DAILY_CHORD_D_GROUP,
      DAILY_ACCUMULATOR_GROUP};
   mblr_reader dut_u (.sys_clk, .arst_n, .slave_addr, .meter_four_path,
      .measurement_unit_select, .rx_data, .rx_valid, .rx_frame_end,
      .tx_data, .tx_valid, .tx_ready, .rec_req, .rec_req_valid, .rec_ack,
      .rec_found, .rec_hdr, .rec_byte_addr, .rec_byte);
   mblr_store_model store_u (.sys_clk, .arst_n, .rec_req, .rec_req_valid,
      .rec_ack, .rec_found, .rec_hdr, .rec_byte_addr, .rec_byte);
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("timeout");
         report_and_stop();
      end
   end
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(logic [7:0] a, fn, logic [15:0] rn, qty, int n,
         logic bad);
      logic [7:0] f[$];
      logic [15:0] c;
      f = {a, fn, rn[15:8], rn[7:0], qty[15:8], qty[7:0]};
      c = crc16(f);
      f.push_back(c[7:0] ^ {7'h00, bad});
      f.push_back(c[15:8]);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         rx_data <= f[i];
         rx_valid <= 1'b1;
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_frame_end <= 1'b1;
      @(posedge sys_clk);
      rx_frame_end <= 1'b0;
   endtask
   task automatic finish_exp();
      logic [15:0] c;
      c = crc16(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
   endtask
   task automatic exp_norm(logic [15:0] idx, logic zero, logic u);
      logic [95:0] h;
      h = {16'h0000, idx, 32'd20220513, 32'd75545};
      exp_q = {slave_addr, 8'h03, 8'h3c};
      for (int k = 11; k >= 0; k--) exp_q.push_back(h[8*k +: 8]);
      for (int k = 0; k < 48; k++)
         exp_q.push_back(zero ? 8'h00 : {u, 1'b0, 6'(k)} ^ idx[7:0]);
      finish_exp();
   endtask
   task automatic resp();
      int idle;
      idle = 0;
      got_q = {};
      for (int i = 0; i < 400 && idle < 40; i++) begin
         @(posedge sys_clk);
         if (rec_req_valid === 1'b1) last_req = rec_req;
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_data);
            idle = 0;
         end else if (got_q.size() > 0) idle++;
      end
      check("length", got_q.size(), exp_q.size());
      foreach (got_q[i])
         if (i < exp_q.size())
            check("byte", got_q[i], exp_q[i]);
   endtask
   task automatic t_chord_a();
      stall <= 1'b1;
      for (int u = 0; u < 2; u++) begin
         measurement_unit_select <= u[0];
         send(slave_addr, 8'h03, 16'h1c23, 16'h001e, 8, 0);
         exp_norm(16'h001e, 0, u[0]);
         resp();
         check("unit", last_req.measurement_unit_select, u);
      end
      stall <= 1'b0;
      measurement_unit_select <= 1'b0;
      $display("chord a test done");
   endtask
   task automatic t_groups();
      int g;
      logic [15:0] idx;
      for (int f = 0; f < 2; f++)
         for (int i = 0; i < 14; i++) begin
            g = i % 7;
            idx = 16'(20 + f);
            meter_four_path <= f[0];
            send(slave_addr, 8'h03, REGS[i] + (f ? ALIAS_OFFSET : 16'h0000),
               idx, 8, 0);
            exp_norm(idx, g == 1 || (!f && g > 3 && g < 6), 0);
            resp();
            check("group", last_req.group, g);
            check("daily", last_req.daily, i >= 7);
            check("index", last_req.index, idx);
         end
      $display("group test done");
   endtask
   task automatic t_exc();
      logic [15:0] rn[9] = '{16'h1c27, 16'h1c2c, 16'h1c45, 16'h1c20,
         16'h1c23, 16'h1c23, 16'h1c23, 16'h1c3c, 16'h1c23};
      logic [15:0] qty[9] = '{1, 1, 1, 1, 1, 0, 4321, 1826, 7};
      logic [7:0] code[9] = '{2, 2, 2, 2, 1, 3, 3, 3, 3};
      for (int i = 0; i < 9; i++) begin
         send(slave_addr, i == 4 ? 8'h04 : 8'h03, rn[i], qty[i], 8, 0);
         exp_q = {slave_addr, (i == 4 ? 8'h04 : 8'h03) | 8'h80, code[i]};
         finish_exp();
         resp();
      end
      send(slave_addr, 8'h03, 16'h1c23, 16'd4320, 8, 0);
      exp_norm(16'd4320, 0, 0);
      resp();
      send(slave_addr, 8'h03, 16'h1c3c, 16'd1825, 8, 0);
      exp_norm(16'd1825, 0, 0);
      resp();
      $display("exception test done");
   endtask
   task automatic t_drop();
      exp_q = {};
      send(slave_addr, 8'h03, 16'h1c23, 16'h0001, 8, 1);
      resp();
      send(8'h21, 8'h03, 16'h1c23, 16'h0001, 8, 0);
      resp();
      send(slave_addr, 8'h03, 16'h1c23, 16'h0001, 7, 0);
      resp();
      $display("drop test done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      @(posedge sys_clk);
      check("reset tx_valid", tx_valid, 0);
      check("reset fetch", rec_req_valid, 0);
      @(posedge sys_clk);
      arst_n <= 1'b1;
      t_chord_a();
      t_groups();
      t_exc();
      t_drop();
      report_and_stop();
   end
endmodule
